// [psq_map.svh]
// Purpose: constants for the program sequencer and its register slave
// Assumes: byte addressing on the register bus, one word per register
// Notes: definitions only
`ifndef PSQ_MAP_SVH
`define PSQ_MAP_SVH
`define PSQ_PC_W            11
`define PSQ_RESET_VEC       11'h000
`define PSQ_VEC_EXT         11'h004
`define PSQ_VEC_TMR         11'h008
`define PSQ_VEC_ADC         11'h00C
`define PSQ_PHASES          4
`define PSQ_PCL_OFS         8'h06
`define PSQ_REG_PCL         12'h018
`define PSQ_REG_STAT        12'h000
`define PSQ_REG_CTRL        12'h004
`define PSQ_REG_PCFULL      12'h008
`define PSQ_SST_CYC         1024
`define PSQ_CLK_MHZ         50
`define PSQ_RESP_OKAY       2'b00
`define PSQ_RESP_SLVERR     2'b10
`endif

// [psq_phase_gen.sv]
// Purpose: divide the system clock into four one-hot phases
// Assumes: synchronous active-low reset
// Notes: phase 0 marks the start of each instruction cycle
`timescale 1ns/10ps
`include "psq_map.svh"
module psq_phase_gen
    import psq_pkg::*;
#(
    parameter int PHASES = `PSQ_PHASES
) (
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    input  wire logic              run,
    output logic [PHASES-1:0]      phase_q
);
    logic [PHASES-1:0] phase_d;
    // rotate the ring only while the pipeline runs
    assign phase_d = run ? {phase_q[PHASES-2:0], phase_q[PHASES-1]} : phase_q;
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            phase_q <= {{(PHASES-1){1'b0}}, 1'b1};
        end else begin
            phase_q <= phase_d;
        end
    end
    AST_ONEHOT: assert property (@(posedge clk_sys) disable iff (!nrst)
        $onehot(phase_q)) else $error("phase ring not one-hot");
endmodule

// [psq_pkg.sv]
// Purpose: types shared by the sequencer files
// Assumes: psq_map.svh holds the numbers
// Notes: none
package psq_pkg;
    typedef enum logic [2:0] {
        PSQ_EV_NONE, PSQ_EV_JUMP, PSQ_EV_RET, PSQ_EV_SKIP,
        PSQ_EV_EXT, PSQ_EV_TMR, PSQ_EV_ADC
    } psq_event_t;
    typedef struct packed {
        psq_event_t   ev;
        logic [10:0]  target;
    } psq_ctl_t;
    typedef enum logic [1:0] {PSQ_RUN, PSQ_HALT, PSQ_WAKE} psq_mode_t;
endpackage

// [psq_pmem_model.sv]
// Purpose: program memory stand-in for the sequencer bench
// Assumes: a read is requested by a one-clock fetch_req pulse
// Notes: each word carries its own address in its low eleven bits
`timescale 1ns/10ps
module psq_pmem_model (
    input  wire logic        clk_sys,
    input  wire logic        req,
    input  wire logic [10:0] addr,
    output logic      [13:0] data
);
    logic [10:0] addr_q;
    logic        req_q;
    logic        tog_q;
    // word held through the request clock and the one after it
    always @(posedge clk_sys) begin
        addr_q <= req ? addr : addr_q;
        req_q  <= req;
        tog_q  <= ~tog_q;
    end
    // toggling filler outside the answer, so a late sample shows up
    assign data = req ? {3'h5, addr} : (req_q ? {3'h5, addr_q} : {14{tog_q}});
    initial tog_q = 1'b0;
endmodule

// [psq_sequencer.sv]
// Purpose: program sequencer with fetch/execute pipeline and register slave
// Assumes: execute path presents control events on phase 3 of each cycle
// Notes: program memory answers in the same clock as fetch_req
//
// Summary of operation
// - four one-hot phases rotate in fixed order each instruction cycle
// - one instruction cycle is exactly four system clock periods
// - next word is fetched while the current word executes
// - any load of the counter flushes the fetched word, a dummy cycle
// - counter steps by one after every program memory fetch except the fetch of a dummy cycle
// - jumps, calls, returns, skips, writes, reset, interrupts load their address
// - true skip discards the fetched word; false skip continues normally
// - counter low byte readable and writable as special register 06H
// - low byte write is a short jump within the current 256-word block
// - wake-up from halt waits 1024 clock periods before fetching resumes
// - any reset clears the counter to address 000H
// - interrupt vectors: 004H external, 008H timer, 00CH conversion
// - taken skip leaves the counter two words past the skip
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "psq_map.svh"
module psq_sequencer
    import psq_pkg::*;
#(
    parameter int PC_W    = `PSQ_PC_W,
    parameter int SST_CYC = `PSQ_SST_CYC
) (
    input  wire logic               clk_sys,
    input  wire logic               nrst,
    // execute path
    input  psq_ctl_t                ctl,
    input  wire logic               halt_req,
    input  wire logic               wake_req,
    input  wire logic               sfr_wr,
    input  wire logic [7:0]         sfr_addr,
    input  wire logic [7:0]         sfr_wdata,
    output logic [7:0]              sfr_rdata_q,
    // program memory
    output logic [PC_W-1:0]         fetch_addr_q,
    output logic                    fetch_req_q,
    input  wire logic [13:0]        fetch_data,
    output logic [13:0]             exec_word_q,
    output logic                    exec_valid_q,
    output logic [3:0]              phase_out_q,
    // AXI4-Lite slave
    input  wire logic [11:0]        s_awaddr,
    input  wire logic               s_awvalid,
    output logic                    s_awready_q,
    input  wire logic [31:0]        s_wdata,
    input  wire logic [3:0]         s_wstrb,
    input  wire logic               s_wvalid,
    output logic                    s_wready_q,
    output logic [1:0]              s_bresp_q,
    output logic                    s_bvalid_q,
    input  wire logic               s_bready,
    input  wire logic [11:0]        s_araddr,
    input  wire logic               s_arvalid,
    output logic                    s_arready_q,
    output logic [31:0]             s_rdata_q,
    output logic [1:0]              s_rresp_q,
    output logic                    s_rvalid_q,
    input  wire logic               s_rready
);
    ////////////////////////////////////////////////////////////////////////////
    logic [3:0]       phase_q;
    logic             wake_busy_q;
    psq_mode_t        mode_q, mode_d;
    logic [PC_W-1:0]  program_counter_q, program_counter_d;
    logic             flush_q, flush_d;
    logic             run;
    logic             wake_start;
    logic             cyc_end;

    // phases only rotate while running; halt freezes the pipeline
    assign run = (mode_q == PSQ_RUN);
    psq_phase_gen #(.PHASES(`PSQ_PHASES)) u_phase (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .run     (run),
        .phase_q (phase_q)
    );
    psq_wake_timer #(.CYC(SST_CYC)) u_wake (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .start   (wake_start),
        .busy_q  (wake_busy_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // halt and wake sequencing
    assign wake_start = (mode_q == PSQ_HALT) && wake_req;
    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            PSQ_RUN:  if (halt_req && cyc_end) mode_d = PSQ_HALT;
            PSQ_HALT: if (wake_req) mode_d = PSQ_WAKE;
            PSQ_WAKE: if (!wake_busy_q && !wake_start) mode_d = PSQ_RUN;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // counter load decode, taken at the last phase of a cycle
    assign cyc_end = phase_q[3];
    wire        bus_pcl_wr;
    wire  [7:0] bus_pcl_val;
    wire        pcl_wr    = sfr_wr && (sfr_addr == `PSQ_PCL_OFS);
    wire        any_pcl   = pcl_wr || bus_pcl_wr;
    wire  [7:0] pcl_val   = pcl_wr ? sfr_wdata : bus_pcl_val;
    wire  [PC_W-1:0] pc_inc  = program_counter_q + 1'b1;
    // short jump keeps the block bits
    wire  [PC_W-1:0] pc_short = {program_counter_q[PC_W-1:8], pcl_val};

    function automatic logic [PC_W-1:0] vec_of(input psq_event_t ev);
        unique case (ev)
            PSQ_EV_EXT: vec_of = PC_W'(`PSQ_VEC_EXT);
            PSQ_EV_TMR: vec_of = PC_W'(`PSQ_VEC_TMR);
            PSQ_EV_ADC: vec_of = PC_W'(`PSQ_VEC_ADC);
            default:    vec_of = PC_W'(`PSQ_RESET_VEC);
        endcase
    endfunction

    wire is_int  = (ctl.ev == PSQ_EV_EXT) || (ctl.ev == PSQ_EV_TMR) || (ctl.ev == PSQ_EV_ADC);
    wire is_xfer = (ctl.ev == PSQ_EV_JUMP) || (ctl.ev == PSQ_EV_RET);
    wire is_skip = (ctl.ev == PSQ_EV_SKIP);
    wire load    = exec_valid_q && (is_int || is_xfer || is_skip || any_pcl);

    // the counter already points past the fetched word, so a skip adds one more
    always_comb begin
        program_counter_d = program_counter_q;
        flush_d           = flush_q;
        if (run && cyc_end) begin
            flush_d = 1'b0;
            if (load) begin
                flush_d = 1'b1;
                if (is_int)       program_counter_d = vec_of(ctl.ev);
                else if (is_xfer) program_counter_d = ctl.target[PC_W-1:0];
                else if (is_skip) program_counter_d = pc_inc;
                else              program_counter_d = pc_short;
            end
        end else if (run && phase_q[0] && !flush_q) begin
            // dummy fetch holds the counter so the target is fetched again
            program_counter_d = pc_inc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pipeline registers: fetch at phase 0, word lands at next phase
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            program_counter_q <= PC_W'(`PSQ_RESET_VEC);
            mode_q            <= PSQ_RUN;
            flush_q           <= 1'b1;
            fetch_addr_q      <= '0;
            fetch_req_q       <= 1'b0;
            exec_word_q       <= '0;
            exec_valid_q      <= 1'b0;
            phase_out_q       <= 4'h1;
        end else begin
            program_counter_q <= program_counter_d;
            mode_q            <= mode_d;
            flush_q           <= flush_d;
            phase_out_q       <= phase_q;
            fetch_req_q       <= run && phase_q[0];
            fetch_addr_q      <= program_counter_q;
            // a dummy cycle executes nothing
            if (fetch_req_q) begin
                exec_word_q  <= fetch_data;
                exec_valid_q <= !flush_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // special register read path
    always_ff @(posedge clk_sys) begin
        if (!nrst) sfr_rdata_q <= '0;
        else       sfr_rdata_q <= (sfr_addr == `PSQ_PCL_OFS) ? program_counter_q[7:0] : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave; bus low-byte writes wait for the next cycle end with a valid word executing
    logic        aw_got_q, w_got_q, pend_q;
    logic [11:0] aw_q;
    logic [7:0]  wd_q;
    logic        ctrl_halt_q;
    wire aw_take = s_awvalid && s_awready_q;
    wire w_take  = s_wvalid && s_wready_q;
    wire wr_go   = aw_got_q && w_got_q && !s_bvalid_q;
    wire wr_pcl  = aw_q == `PSQ_REG_PCL;
    wire wr_ctrl = aw_q == `PSQ_REG_CTRL;
    assign bus_pcl_wr  = pend_q && !pcl_wr;
    assign bus_pcl_val = wd_q;
    wire pend_done = pend_q && run && cyc_end && exec_valid_q;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            aw_got_q <= 1'b0; w_got_q <= 1'b0; pend_q <= 1'b0;
            aw_q <= '0; wd_q <= '0; ctrl_halt_q <= 1'b0;
            s_awready_q <= 1'b1; s_wready_q <= 1'b1;
            s_bvalid_q <= 1'b0; s_bresp_q <= `PSQ_RESP_OKAY;
        end else begin
            if (aw_take) begin aw_got_q <= 1'b1; aw_q <= s_awaddr; s_awready_q <= 1'b0; end
            if (w_take) begin
                w_got_q <= 1'b1; s_wready_q <= 1'b0;
                if (s_wstrb[0]) wd_q <= s_wdata[7:0];
            end
            if (pend_done) pend_q <= 1'b0;
            if (wr_go) begin
                aw_got_q <= 1'b0; w_got_q <= 1'b0; s_bvalid_q <= 1'b1;
                s_bresp_q <= (wr_pcl || wr_ctrl) ? `PSQ_RESP_OKAY : `PSQ_RESP_SLVERR;
                if (wr_pcl) pend_q <= 1'b1;
                if (wr_ctrl) ctrl_halt_q <= wd_q[0];
            end
            if (s_bvalid_q && s_bready) begin
                s_bvalid_q <= 1'b0; s_awready_q <= 1'b1; s_wready_q <= 1'b1;
            end
        end
    end

    wire [31:0] rd_mux =
        (s_araddr == `PSQ_REG_PCL)    ? {24'h0, program_counter_q[7:0]} :
        (s_araddr == `PSQ_REG_PCFULL) ? {21'h0, program_counter_q} :
        (s_araddr == `PSQ_REG_CTRL)   ? {31'h0, ctrl_halt_q} :
        (s_araddr == `PSQ_REG_STAT)   ? {27'h0, pend_q, wake_busy_q, mode_q, exec_valid_q} :
        32'h0;
    wire rd_ok = (s_araddr == `PSQ_REG_PCL) || (s_araddr == `PSQ_REG_PCFULL) ||
                 (s_araddr == `PSQ_REG_CTRL) || (s_araddr == `PSQ_REG_STAT);
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            s_arready_q <= 1'b1; s_rvalid_q <= 1'b0;
            s_rdata_q <= '0; s_rresp_q <= `PSQ_RESP_OKAY;
        end else if (s_arvalid && s_arready_q) begin
            s_arready_q <= 1'b0; s_rvalid_q <= 1'b1;
            s_rdata_q <= rd_mux;
            s_rresp_q <= rd_ok ? `PSQ_RESP_OKAY : `PSQ_RESP_SLVERR;
        end else if (s_rvalid_q && s_rready) begin
            s_rvalid_q <= 1'b0; s_arready_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    AST_FOUR: assert property (@(posedge clk_sys) disable iff (!nrst)
        (run && phase_q[0]) ##1 run[*3] |=> phase_q[0])
        else $error("cycle not four clocks");
    AST_PHASE_ORDER: assert property (@(posedge clk_sys) disable iff (!nrst)
        (run && phase_q[0]) |=> phase_q[1])
        else $error("phase order broken");
    AST_INC: assert property (@(posedge clk_sys) disable iff (!nrst)
        (run && phase_q[0] && !flush_q) |=> program_counter_q == $past(program_counter_q) + 1'b1)
        else $error("no increment after fetch");
    AST_DUMMY_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
        (run && phase_q[0] && flush_q) |=> program_counter_q == $past(program_counter_q))
        else $error("counter moved in dummy cycle");
    AST_VEC: assert property (@(posedge clk_sys) disable iff (!nrst)
        (run && cyc_end && exec_valid_q && ctl.ev == PSQ_EV_TMR)
        |=> program_counter_q == 11'h008)
        else $error("timer vector wrong");
    AST_FLUSH: assert property (@(posedge clk_sys) disable iff (!nrst)
        (run && cyc_end && load && !halt_req) |-> ##3 !exec_valid_q)
        else $error("no dummy cycle");
    AST_SHORT: assert property (@(posedge clk_sys) disable iff (!nrst)
        (run && cyc_end && exec_valid_q && pcl_wr && ctl.ev == PSQ_EV_NONE)
        |=> program_counter_q == {$past(program_counter_q[10:8]), $past(sfr_wdata)})
        else $error("short jump left block");
    AST_SKIP: assert property (@(posedge clk_sys) disable iff (!nrst)
        (run && cyc_end && exec_valid_q && is_skip)
        |=> program_counter_q == $past(program_counter_q) + 1'b1)
        else $error("skip target wrong");
    AST_WAKE: assert property (@(posedge clk_sys) disable iff (!nrst)
        wake_start |=> !run [*8])
        else $error("ran during start-up delay");
    AST_RESET: assert property (@(posedge clk_sys)
        !nrst |=> program_counter_q == 11'h000)
        else $error("counter not cleared at reset");
    COV_SKIP: cover property (@(posedge clk_sys) run && cyc_end && exec_valid_q && is_skip);
    COV_INT:  cover property (@(posedge clk_sys) run && cyc_end && exec_valid_q && is_int);
    COV_WAKE: cover property (@(posedge clk_sys) mode_q == PSQ_WAKE ##1 mode_q == PSQ_RUN);
    COV_BUSPCL: cover property (@(posedge clk_sys) pend_done);
endmodule

// [psq_sequencer_tb.sv]
// Purpose: self-checking bench for the program sequencer
// Assumes: word address visible in exec_word_q[10:0] via the memory model
// Notes: start-up delay shortened to SST clocks
`timescale 1ns/10ps
`include "psq_map.svh"
module psq_sequencer_tb
    import psq_pkg::*;
;
    localparam int SST = 16;
    typedef struct {psq_event_t ev; logic [10:0] tgt; logic [10:0] exp; logic rel; logic sfr;} psq_row_t;
    logic        clk_sys, nrst, halt_req, wake_req, sfr_wr;
    psq_ctl_t    ctl;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata_q;
    logic [10:0] fetch_addr_q;
    logic [13:0] fetch_data, exec_word_q;
    logic        fetch_req_q, exec_valid_q;
    logic [3:0]  phase_out_q, s_wstrb;
    logic [11:0] s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata_q;
    logic [1:0]  s_bresp_q, s_rresp_q;
    logic        s_awvalid, s_awready_q, s_wvalid, s_wready_q, s_bvalid_q, s_bready;
    logic        s_arvalid, s_arready_q, s_rvalid_q, s_rready;
    int          num_errors = 0;
    int          checked = 0;
    psq_sequencer #(.SST_CYC(SST)) psq_sequencer_i (.clk_sys(clk_sys), .nrst(nrst), .ctl(ctl),
        .halt_req(halt_req), .wake_req(wake_req), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .fetch_addr_q(fetch_addr_q),
        .fetch_req_q(fetch_req_q), .fetch_data(fetch_data), .exec_word_q(exec_word_q),
        .exec_valid_q(exec_valid_q), .phase_out_q(phase_out_q), .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid), .s_awready_q(s_awready_q), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid), .s_wready_q(s_wready_q), .s_bresp_q(s_bresp_q),
        .s_bvalid_q(s_bvalid_q), .s_bready(s_bready), .s_araddr(s_araddr),
        .s_arvalid(s_arvalid), .s_arready_q(s_arready_q), .s_rdata_q(s_rdata_q),
        .s_rresp_q(s_rresp_q), .s_rvalid_q(s_rvalid_q), .s_rready(s_rready));
    psq_pmem_model psq_pmem_model_i (.clk_sys(clk_sys), .req(fetch_req_q),
        .addr(fetch_addr_q), .data(fetch_data));
    ////////////////////////////////////////////////////////////////////////
    // ordinary control events: event, target, expected word, relative, sfr
    psq_row_t rows [9] = '{
        '{PSQ_EV_JUMP, 11'h123, 11'h123, 1'b0, 1'b0},
        '{PSQ_EV_RET,  11'h055, 11'h055, 1'b0, 1'b0},
        '{PSQ_EV_EXT,  11'h000, 11'h004, 1'b0, 1'b0},
        '{PSQ_EV_TMR,  11'h000, 11'h008, 1'b0, 1'b0},
        '{PSQ_EV_ADC,  11'h000, 11'h00C, 1'b0, 1'b0},
        '{PSQ_EV_SKIP, 11'h000, 11'h002, 1'b1, 1'b0},
        '{PSQ_EV_JUMP, 11'h5F0, 11'h5F0, 1'b0, 1'b0},
        '{PSQ_EV_NONE, 11'h022, 11'h522, 1'b0, 1'b1},
        '{PSQ_EV_JUMP, 11'h7FE, 11'h7FE, 1'b0, 1'b0}};
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
        chk_val(nm, {30'h0, e}, {30'h0, g});
    endtask
    task automatic hang(input string nm);
        num_errors++;
        $display("MISMATCH %s expected answer seen timeout", nm);
        end_of_test();
    endtask
    ////////////////////////////////////////////////////////////////////////
    // bus master: hold each channel until its own ready is sampled
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_awaddr <= a; s_awvalid <= 1'b1; s_wdata <= d; s_wstrb <= 4'hF;
        s_wvalid <= 1'b1; s_bready <= 1'b1;
        do begin
            tick(1); n++;
            if (s_awvalid && s_awready_q === 1'b1) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready_q === 1'b1) s_wvalid <= 1'b0;
        end while (s_bvalid_q !== 1'b1 && n < 50);
        if (s_bvalid_q !== 1'b1) hang("bvalid");
        r = s_bresp_q;
    endtask
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
        do begin
            tick(1); n++;
            if (s_arvalid && s_arready_q === 1'b1) s_arvalid <= 1'b0;
        end while (s_rvalid_q !== 1'b1 && n < 50);
        if (s_rvalid_q !== 1'b1) hang("rvalid");
        d = s_rdata_q; r = s_rresp_q;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic next_fetch(input int lim, output int g);
        g = 0;
        do begin tick(1); g++; end while (fetch_req_q !== 1'b1 && g < lim);
        if (fetch_req_q !== 1'b1) hang("fetch_req");
    endtask
    task automatic sync();
        int n;
        n = 0;
        while (!(phase_out_q === 4'h1 && exec_valid_q === 1'b1) && n < 40) begin tick(1); n++; end
        if (n == 40) hang("cycle_start");
    endtask
    task automatic wait_valid(input logic v);
        int n;
        n = 0;
        while (exec_valid_q !== v && n < 40) begin tick(1); n++; end
        if (n == 40) hang("exec_valid");
    endtask
    task automatic do_reset(input int n);
        int g;
        nrst <= 1'b0; tick(n); nrst <= 1'b1;
        next_fetch(40, g);
        chk_val("first_fetch", 11'h000, fetch_addr_q);
    endtask
    // event offered for four clocks from phase 2 to phase 1, sampled once at the phase 3 cycle end
    task automatic do_event(input psq_row_t rw);
        logic [10:0] s;
        tick(8); sync();
        ctl <= '{rw.ev, rw.tgt}; sfr_wr <= rw.sfr; sfr_addr <= 8'h06; sfr_wdata <= rw.tgt[7:0];
        repeat (4) begin
            tick(1);
            if (phase_out_q === 4'h8) s = exec_word_q[10:0];
        end
        ctl <= '{PSQ_EV_NONE, 11'h000}; sfr_wr <= 1'b0;
        wait_valid(1'b0);
        wait_valid(1'b1);
        chk_val("exec_addr", rw.rel ? s + rw.exp : rw.exp, exec_word_q[10:0]);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [3:0]  ph;
        int          g, p, n;
        nrst = 1'b0; ctl = '{PSQ_EV_NONE, 11'h000}; halt_req = 1'b0; wake_req = 1'b0;
        sfr_wr = 1'b0; sfr_addr = 8'h00; sfr_wdata = 8'h00; s_awaddr = 12'h000;
        s_awvalid = 1'b0; s_wdata = 32'h0; s_wstrb = 4'h0; s_wvalid = 1'b0; s_bready = 1'b0;
        s_araddr = 12'h000; s_arvalid = 1'b0; s_rready = 1'b0;
        do_reset(20);
        sync(); ph = 4'h1;
        repeat (8) begin
            chk_val("phase", ph, phase_out_q);
            ph = {ph[2:0], ph[3]}; tick(1);
        end
        $display("done: phases");
        foreach (rows[i]) do_event(rows[i]);
        $display("done: event rows");
        // straight run across the top of memory, one word per cycle
        next_fetch(20, g); p = fetch_addr_q;
        repeat (4) begin
            next_fetch(20, g);
            chk_val("fetch_addr", 11'(p + 1), fetch_addr_q);
            chk_val("fetch_gap", 4, g);
            chk_val("exec_valid", 1'b1, exec_valid_q);
            p = fetch_addr_q;
        end
        $display("done: sequential");
        axi_wr(`PSQ_REG_CTRL, 32'h1, r); chk_resp("ctrl_wr", `PSQ_RESP_OKAY, r);
        axi_rd(`PSQ_REG_CTRL, d, r); chk_val("ctrl_rd", 1'b1, d[0]);
        axi_rd(12'h100, d, r); chk_resp("bad_rd", `PSQ_RESP_SLVERR, r);
        chk_val("bad_rdata", 32'h0, d);
        axi_wr(12'h100, 32'h5, r); chk_resp("bad_wr", `PSQ_RESP_SLVERR, r);
        $display("done: registers");
        halt_req <= 1'b1; tick(4); halt_req <= 1'b0; tick(12);
        axi_rd(`PSQ_REG_STAT, d, r); chk_val("stat_mode", PSQ_HALT, d[2:1]);
        axi_rd(`PSQ_REG_PCFULL, d, r);
        sfr_addr <= 8'h06; tick(2); chk_val("sfr_low", d[7:0], sfr_rdata_q);
        sfr_addr <= 8'h07; tick(2); chk_val("sfr_other", 8'h00, sfr_rdata_q);
        n = 0;
        repeat (20) begin tick(1); if (fetch_req_q === 1'b1) n++; end
        chk_val("halt_fetches", 0, n);
        wake_req <= 1'b1; tick(1); wake_req <= 1'b0;
        next_fetch(SST + 40, g);
        chk_val("wake_delay", 1'b1, g >= SST && g <= SST + 8);
        $display("done: halt and wake");
        tick(5); do_reset(3);
        $display("done: second reset");
        end_of_test();
    end
    initial begin
        tick(90000);
        hang("run_limit");
    end
endmodule

// [psq_wake_timer.sv]
// Purpose: start-up delay counter after wake-up from halt
// Assumes: start is a one-cycle pulse
// Notes: busy stays high for exactly CYC clock periods
`timescale 1ns/10ps
`include "psq_map.svh"
module psq_wake_timer
    import psq_pkg::*;
#(
    parameter int CYC = `PSQ_SST_CYC
) (
    input  wire logic  clk_sys,
    input  wire logic  nrst,
    input  wire logic  start,
    output logic       busy_q
);
    localparam int CW = $clog2(CYC + 1);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    // load on start, count down to zero
    assign cnt_d = start ? CW'(CYC) : ((cnt_q != '0) ? cnt_q - 1'b1 : cnt_q);
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            busy_q <= (cnt_d != '0);
        end
    end
endmodule
